// [pscs_pkg.sv]
// Constants and types for the PLL start-up clock supervisor
// Function
// - A set lock flag alone never marks the PLL as running.
// - Once validated, PLL stays valid across disable and re-enable until reset.
// - PLL selected but not running stalls the CPU.
// - Single-shot comparator results with early done or error are invalid.
// - Standby is unsupported; only idle and halt low-power modes exist.
// - Clearing the PLL clock select switches system clock to oscillator.
// - A larger divider select value lowers the system clock rate.
// - Per-peripheral clock enables gate peripheral clocks off.
package pscs_pkg;
  localparam int unsigned CNT_W        = 20;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_DIV       = 8'h04;
  localparam logic [7:0] OFF_PCLK      = 8'h08;
  localparam logic [7:0] OFF_PLL_STATUS_REG    = 8'h0C;
  localparam logic [7:0] OFF_CMPCTL    = 8'h10;
  localparam logic [7:0] OFF_REFCNT    = 8'h14;
  localparam logic [7:0] OFF_MEASCNT   = 8'h18;
  localparam logic [7:0] OFF_VALIDCNT  = 8'h1C;
  localparam logic [7:0] OFF_ISTAT     = 8'h20;
  localparam logic [7:0] OFF_IMASK     = 8'h24;
  // Field positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_SEL_BIT = 1;
  localparam int unsigned CTRL_LPM_LSB = 2;
  localparam int unsigned ST_LOCK_BIT  = 0;
  localparam int unsigned ST_VALID_BIT = 1;
  localparam int unsigned ST_RUN_BIT   = 2;
  localparam int unsigned ST_STALL_BIT = 3;
  localparam int unsigned ST_CNT_LSB   = 8;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_ERR      = 1;
  localparam int unsigned IRQ_LOCK     = 2;
  localparam int unsigned IRQ_STALL    = 3;
  localparam int unsigned IRQ_W        = 4;
  // Reset values
  localparam logic [7:0]       DIV_RST    = 8'h00;
  localparam logic [7:0]       PCLK_RST   = 8'hFF;
  localparam logic [CNT_W-1:0] REF_RST    = 20'h003E8;
  localparam logic [CNT_W-1:0] MEAS_RST   = 20'h00FA0;
  localparam logic [CNT_W-1:0] VALID_RST  = 20'h00014;
  localparam logic [IRQ_W-1:0] MASK_RST   = 4'h0;
  // Timing
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned PLL_IDLE_NS  = 1000;
  localparam int unsigned IDLE_W       = 9;
  localparam logic [IDLE_W-1:0] PLL_IDLE_CYC = IDLE_W'((PLL_IDLE_NS * CLK_MHZ + 999) / 1000);
  typedef enum logic [1:0] {
    LPM_RUN     = 2'b00,
    LPM_IDLE    = 2'b01,
    LPM_HALT    = 2'b10,
    LPM_STANDBY = 2'b11
  } pscs_lpm_e;
  typedef enum logic [1:0] {
    CMP_IDLE   = 2'b00,
    CMP_REF    = 2'b01,
    CMP_WINDOW = 2'b10
  } pscs_cmp_e;
endpackage

// [pscs_cmp_if.sv]
// Signals between the supervisor top and its clock comparator
`timescale 1ns/100ps
`default_nettype none
interface pscs_cmp_if;
  logic                         start;
  logic [pscs_pkg::CNT_W-1:0]   ref_seed;
  logic [pscs_pkg::CNT_W-1:0]   meas_seed;
  logic [pscs_pkg::CNT_W-1:0]   valid_seed;
  logic                         ref_tick;
  logic                         meas_tick;
  logic [pscs_pkg::CNT_W-1:0]   ref_cnt;
  logic [pscs_pkg::CNT_W-1:0]   meas_cnt;
  logic [pscs_pkg::CNT_W-1:0]   valid_cnt;
  logic                         busy;
  logic                         done;
  logic                         error;
  modport ctl (output start, ref_seed, meas_seed, valid_seed, ref_tick, meas_tick,
               input ref_cnt, meas_cnt, valid_cnt, busy, done, error);
  modport cmp (input start, ref_seed, meas_seed, valid_seed, ref_tick, meas_tick,
               output ref_cnt, meas_cnt, valid_cnt, busy, done, error);
endinterface
`default_nettype wire

// [pscs_comparator.sv]
// Single-shot clock comparator: reference window against measured clock
`timescale 1ns/100ps
`default_nettype none
module pscs_comparator (
  input  wire logic clk,   // System clock
  input  wire logic rst_n, // Synchronous reset, active low
  pscs_cmp_if.cmp   cmp    // Comparator port
);
  pscs_pkg::pscs_cmp_e          state_r;
  logic [pscs_pkg::CNT_W-1:0]   ref_r;
  logic [pscs_pkg::CNT_W-1:0]   meas_r;
  logic [pscs_pkg::CNT_W-1:0]   valid_r;
  logic                         done_r;
  logic                         err_r;
  logic                         ref_z;
  logic                         meas_z;
  logic                         valid_z;
  logic                         hit_done;
  logic                         hit_err;

  assign ref_z   = (ref_r == '0);
  assign meas_z  = (meas_r == '0);
  assign valid_z = (valid_r == '0);
  // Done once the measured count runs out in the window; the window count is then cleared, so a clean run never looks premature
  assign hit_done = (state_r == pscs_pkg::CMP_WINDOW) && meas_z;
  // Measured too fast before the window, or window closed with counts left
  assign hit_err  = ((state_r == pscs_pkg::CMP_REF) && meas_z && !ref_z) ||
                    ((state_r == pscs_pkg::CMP_WINDOW) && !meas_z && valid_z);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= pscs_pkg::CMP_IDLE;
    end else if (cmp.start) begin
      state_r <= pscs_pkg::CMP_REF;
    end else begin
      case (state_r)
        pscs_pkg::CMP_IDLE:   state_r <= pscs_pkg::CMP_IDLE;
        pscs_pkg::CMP_REF: begin
          if (hit_err) state_r <= pscs_pkg::CMP_IDLE;
          else if (ref_z) state_r <= pscs_pkg::CMP_WINDOW;
        end
        pscs_pkg::CMP_WINDOW: begin
          if (hit_done || hit_err) state_r <= pscs_pkg::CMP_IDLE;
        end
        default:              state_r <= pscs_pkg::CMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_r   <= '0;
      meas_r  <= '0;
      valid_r <= '0;
    end else if (cmp.start) begin
      ref_r   <= cmp.ref_seed;
      meas_r  <= cmp.meas_seed;
      valid_r <= cmp.valid_seed;
    end else if (hit_done) begin
      valid_r <= '0;
    end else if (state_r != pscs_pkg::CMP_IDLE && !hit_err) begin
      if (cmp.meas_tick && !meas_z) meas_r <= meas_r - pscs_pkg::CNT_ONE;
      if (cmp.ref_tick && state_r == pscs_pkg::CMP_REF && !ref_z) ref_r <= ref_r - pscs_pkg::CNT_ONE;
      if (cmp.ref_tick && state_r == pscs_pkg::CMP_WINDOW && !valid_z) valid_r <= valid_r - pscs_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
    end else begin
      done_r <= hit_done && !cmp.start;
      err_r  <= hit_err && !cmp.start;
    end
  end

  assign cmp.ref_cnt   = ref_r;
  assign cmp.meas_cnt  = meas_r;
  assign cmp.valid_cnt = valid_r;
  assign cmp.busy      = (state_r != pscs_pkg::CMP_IDLE);
  assign cmp.done      = done_r;
  assign cmp.error     = err_r;
endmodule
`default_nettype wire

// [pscs_top.sv]
// PLL start-up supervisor with clock comparator, clock select and gating
`timescale 1ns/100ps
`default_nettype none
module pscs_top (
  input  wire logic        clk,            // System clock, 250 MHz
  input  wire logic        rst_n,          // Synchronous reset, active low
  input  wire logic        hsel,           // AHB slave select
  input  wire logic [31:0] haddr,          // AHB address
  input  wire logic [1:0]  htrans,         // AHB transfer type
  input  wire logic        hwrite,         // AHB write
  input  wire logic [2:0]  hsize,          // AHB size
  input  wire logic        hready,         // AHB bus ready
  input  wire logic [31:0] hwdata,         // AHB write data
  output logic             hreadyout,      // AHB slave ready
  output logic [31:0]      hrdata,         // AHB read data
  output logic             hresp,          // AHB response, always OKAY
  input  wire logic        osc_clk_in,     // Oscillator clock pin
  input  wire logic        pll_clk_in,     // PLL output clock pin
  input  wire logic        pll_lock_in,    // PLL lock flag pin
  input  wire logic        wake_req,       // Wake from low-power mode
  output logic             pll_enable,     // PLL power enable
  output logic             system_clock_src_pll, // System clock from PLL
  output logic             system_clock_tick,    // Divided system clock tick
  output logic             cpu_stall,      // CPU halted by dead clock
  output logic             lpm_idle,       // Idle mode active
  output logic             lpm_halt,       // Halt mode active
  output logic [7:0]       periph_clk_en,  // Per-peripheral clock enables
  output logic             irq             // Interrupt, level
);
  localparam int unsigned OSC = 0;
  localparam int unsigned PLL = 1;
  localparam int unsigned LCK = 2;

  pscs_cmp_if cif ();

  // Pin synchronisers, a change counts once stages two and three agree
  logic [2:0] pin_in;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  assign pin_in = {pll_lock_in, pll_clk_in, osc_clk_in};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      logic [2:0] sh_r;
      logic       lvl_r;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sh_r  <= 3'h0;
          lvl_r <= 1'b0;
        end else begin
          sh_r <= {sh_r[1:0], pin_in[g]};
          if (sh_r[1] == sh_r[2]) lvl_r <= sh_r[2];
        end
      end
      assign pin_lvl[g]  = lvl_r;
      assign pin_rise[g] = (sh_r[1] == sh_r[2]) && sh_r[2] && !lvl_r;
    end
  endgenerate

  // Control registers
  logic                        pll_en_r;
  logic                        pll_sel_r;
  pscs_pkg::pscs_lpm_e         lpm_r;
  logic [7:0]                  div_r;
  logic [7:0]                  pclk_r;
  logic [pscs_pkg::CNT_W-1:0]  ref_seed_r;
  logic [pscs_pkg::CNT_W-1:0]  meas_seed_r;
  logic [pscs_pkg::CNT_W-1:0]  valid_seed_r;
  logic [pscs_pkg::IRQ_W-1:0]  mask_r;
  logic [pscs_pkg::IRQ_W-1:0]  stat_r;
  logic [pscs_pkg::IRQ_W-1:0]  events;
  logic                        start_r;

  // Supervisor state
  logic [pscs_pkg::IDLE_W-1:0] idle_cnt_r;
  logic                        pll_run_r;
  logic                        pll_valid_r;
  logic                        stall_r;
  logic [7:0]                  lock_cnt_r;
  logic [7:0]                  div_cnt_r;
  logic                        tick_r;
  logic                        idle_r;
  logic                        halt_r;
  logic [7:0]                  pclk_out_r;

  // Bus slave
  logic                        ap_take;
  logic                        wr_pend_r;
  logic [7:0]                  wr_addr_r;
  logic [31:0]                 rd_mux;
  logic [31:0]                 hrdata_r;
  logic [1:0]                  lpm_wr;
  logic                        src_edge;

  assign ap_take   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign lpm_wr    = hwdata[pscs_pkg::CTRL_LPM_LSB +: 2];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ap_take && hwrite && (hsize == 3'b010) && (haddr[31:8] == 24'h000000);
      wr_addr_r <= haddr[7:0];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        pscs_pkg::OFF_CTRL: begin
          rd_mux[pscs_pkg::CTRL_EN_BIT]          = pll_en_r;
          rd_mux[pscs_pkg::CTRL_SEL_BIT]         = pll_sel_r;
          rd_mux[pscs_pkg::CTRL_LPM_LSB +: 2]    = lpm_r;
        end
        pscs_pkg::OFF_DIV:      rd_mux[7:0] = div_r;
        pscs_pkg::OFF_PCLK:     rd_mux[7:0] = pclk_r;
        pscs_pkg::OFF_PLL_STATUS_REG: begin
          rd_mux[pscs_pkg::ST_LOCK_BIT]          = pin_lvl[LCK];
          rd_mux[pscs_pkg::ST_VALID_BIT]         = pll_valid_r;
          rd_mux[pscs_pkg::ST_RUN_BIT]           = pll_run_r;
          rd_mux[pscs_pkg::ST_STALL_BIT]         = stall_r;
          rd_mux[pscs_pkg::ST_CNT_LSB +: 8]      = lock_cnt_r;
        end
        pscs_pkg::OFF_CMPCTL:   rd_mux[0] = cif.busy;
        pscs_pkg::OFF_REFCNT:   rd_mux[pscs_pkg::CNT_W-1:0] = cif.ref_cnt;
        pscs_pkg::OFF_MEASCNT:  rd_mux[pscs_pkg::CNT_W-1:0] = cif.meas_cnt;
        pscs_pkg::OFF_VALIDCNT: rd_mux[pscs_pkg::CNT_W-1:0] = cif.valid_cnt;
        pscs_pkg::OFF_ISTAT:    rd_mux[pscs_pkg::IRQ_W-1:0] = stat_r;
        pscs_pkg::OFF_IMASK:    rd_mux[pscs_pkg::IRQ_W-1:0] = mask_r;
        default:                rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata_r <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata_r <= rd_mux;
    end
  end

  // Software-written control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_en_r     <= 1'b0;
      pll_sel_r    <= 1'b0;
      div_r        <= pscs_pkg::DIV_RST;
      pclk_r       <= pscs_pkg::PCLK_RST;
      ref_seed_r   <= pscs_pkg::REF_RST;
      meas_seed_r  <= pscs_pkg::MEAS_RST;
      valid_seed_r <= pscs_pkg::VALID_RST;
      mask_r       <= pscs_pkg::MASK_RST;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        pscs_pkg::OFF_CTRL: begin
          pll_en_r  <= hwdata[pscs_pkg::CTRL_EN_BIT];
          pll_sel_r <= hwdata[pscs_pkg::CTRL_SEL_BIT];
        end
        pscs_pkg::OFF_DIV:      div_r        <= hwdata[7:0];
        pscs_pkg::OFF_PCLK:     pclk_r       <= hwdata[7:0];
        pscs_pkg::OFF_REFCNT:   ref_seed_r   <= hwdata[pscs_pkg::CNT_W-1:0];
        pscs_pkg::OFF_MEASCNT:  meas_seed_r  <= hwdata[pscs_pkg::CNT_W-1:0];
        pscs_pkg::OFF_VALIDCNT: valid_seed_r <= hwdata[pscs_pkg::CNT_W-1:0];
        pscs_pkg::OFF_IMASK:    mask_r       <= hwdata[pscs_pkg::IRQ_W-1:0];
        default:                mask_r       <= mask_r;
      endcase
    end
  end

  // Comparator start pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_pend_r && (wr_addr_r == pscs_pkg::OFF_CMPCTL) && hwdata[0];
    end
  end

  // Low-power mode; a standby request is dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpm_r <= pscs_pkg::LPM_RUN;
    end else if (wake_req) begin
      lpm_r <= pscs_pkg::LPM_RUN;
    end else if (wr_pend_r && wr_addr_r == pscs_pkg::OFF_CTRL &&
                 lpm_wr != pscs_pkg::LPM_STANDBY) begin
      lpm_r <= pscs_pkg::pscs_lpm_e'(lpm_wr);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_r     <= 1'b0;
      halt_r     <= 1'b0;
      pclk_out_r <= 8'h00;
    end else begin
      idle_r     <= (lpm_r == pscs_pkg::LPM_IDLE);
      halt_r     <= (lpm_r == pscs_pkg::LPM_HALT);
      pclk_out_r <= (lpm_r == pscs_pkg::LPM_HALT) ? 8'h00 : pclk_r;
    end
  end

  // PLL activity: only real output edges prove a running clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_cnt_r <= pscs_pkg::PLL_IDLE_CYC;
      pll_run_r  <= 1'b0;
    end else begin
      if (pin_rise[PLL] && pll_en_r) begin
        idle_cnt_r <= '0;
      end else if (idle_cnt_r != pscs_pkg::PLL_IDLE_CYC) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
      pll_run_r <= pll_en_r && (idle_cnt_r != pscs_pkg::PLL_IDLE_CYC);
    end
  end

  // Validation sticks until the next reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_valid_r <= 1'b0;
    end else if (cif.done && pll_en_r && pll_run_r) begin
      pll_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_cnt_r <= 8'h00;
    end else if (pin_rise[LCK] && lock_cnt_r != 8'hFF) begin
      lock_cnt_r <= lock_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall_r <= 1'b0;
    end else begin
      stall_r <= pll_sel_r && !pll_run_r;
    end
  end

  // System clock divider on the selected source
  assign src_edge = pll_sel_r ? pin_rise[PLL] : pin_rise[OSC];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (src_edge && lpm_r != pscs_pkg::LPM_HALT) begin
        if (div_cnt_r >= div_r) begin
          div_cnt_r <= 8'h00;
          tick_r    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // Interrupt status, set wins over a write-one clear
  assign events[pscs_pkg::IRQ_DONE]  = cif.done;
  assign events[pscs_pkg::IRQ_ERR]   = cif.error;
  assign events[pscs_pkg::IRQ_LOCK]  = pin_rise[LCK];
  assign events[pscs_pkg::IRQ_STALL] = pll_sel_r && !pll_run_r && !stall_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else if (wr_pend_r && wr_addr_r == pscs_pkg::OFF_ISTAT) begin
      stat_r <= (stat_r & ~hwdata[pscs_pkg::IRQ_W-1:0]) | events;
    end else begin
      stat_r <= stat_r | events;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & mask_r);
    end
  end

  // Comparator: oscillator is the reference, PLL output is measured
  assign cif.start      = start_r;
  assign cif.ref_seed   = ref_seed_r;
  assign cif.meas_seed  = meas_seed_r;
  assign cif.valid_seed = valid_seed_r;
  assign cif.ref_tick   = pin_rise[OSC];
  assign cif.meas_tick  = pin_rise[PLL];

  pscs_comparator u_cmp (
    .clk   (clk),
    .rst_n (rst_n),
    .cmp   (cif.cmp)
  );

  assign pll_enable     = pll_en_r;
  assign system_clock_src_pll = pll_sel_r;
  assign system_clock_tick    = tick_r;
  assign cpu_stall      = stall_r;
  assign lpm_idle       = idle_r;
  assign lpm_halt       = halt_r;
  assign periph_clk_en  = pclk_out_r;
endmodule
`default_nettype wire

// [pscs_top_checker.sv]
// Port-level assertions for the PLL start-up supervisor
`timescale 1ns/100ps
`default_nettype none
module pscs_top_checker (
  input wire logic        clk,            // Clock
  input wire logic        rst_n,          // Reset
  input wire logic        hsel,           // Select
  input wire logic [31:0] haddr,          // Address
  input wire logic [1:0]  htrans,         // Transfer type
  input wire logic        hwrite,         // Write
  input wire logic [2:0]  hsize,          // Size
  input wire logic [31:0] hwdata,         // Write data
  input wire logic        hreadyout,      // Ready
  input wire logic        hresp,          // Response
  input wire logic        wake_req,       // Wake
  input wire logic        pll_enable,     // PLL on
  input wire logic        system_clock_src_pll, // PLL selected
  input wire logic        system_clock_tick,    // Tick
  input wire logic        cpu_stall,      // Stall
  input wire logic        lpm_idle,       // Idle
  input wire logic        lpm_halt,       // Halt
  input wire logic [7:0]  periph_clk_en,  // Clock enables
  input wire logic        irq             // Interrupt
);
  logic wr;
  assign wr = hsel && htrans[1] && hwrite && hsize == 3'b010 && haddr[31:8] == 24'h000000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_CTRL_WR: assert property (
    wr && haddr[7:0] == 8'h00 ##1 1'b1 |=> system_clock_src_pll == $past(hwdata[1]) && pll_enable == $past(hwdata[0]))
    else $error("control write not applied");
  AST_STALL_OFF: assert property (!system_clock_src_pll |=> !cpu_stall)
    else $error("stall on oscillator");
  AST_STALL_DEAD: assert property (system_clock_src_pll && !pll_enable ##1 system_clock_src_pll |=> cpu_stall)
    else $error("no stall on disabled PLL");
  AST_ONE_MODE: assert property (!(lpm_idle && lpm_halt))
    else $error("two modes at once");
  AST_HALT_GATE: assert property (
    lpm_halt && $past(lpm_halt) |-> periph_clk_en == 8'h00 && !system_clock_tick)
    else $error("clocks run in halt");
  AST_TICK_PULSE: assert property (system_clock_tick |=> !system_clock_tick)
    else $error("tick longer than a cycle");
  AST_PCLK_WR: assert property (
    wr && haddr[7:0] == 8'h08 ##1 !lpm_halt |=> ##1 (lpm_halt || periph_clk_en == $past(hwdata[7:0], 2)))
    else $error("clock enables not applied");
  AST_WAKE: assert property (wake_req |-> ##[1:2] !lpm_idle && !lpm_halt)
    else $error("wake ignored");
  AST_IRQ_OFF: assert property (wr && haddr[7:0] == 8'h24 ##1 hwdata[3:0] == 4'h0 |-> ##[1:2] !irq)
    else $error("masked interrupt raised");
  cover property ($rose(cpu_stall));
  cover property ($rose(irq));
  cover property ($rose(lpm_halt));
endmodule
bind pscs_top pscs_top_checker u_chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req),
  .pll_enable(pll_enable), .system_clock_src_pll(system_clock_src_pll), .system_clock_tick(system_clock_tick),
  .cpu_stall(cpu_stall), .lpm_idle(lpm_idle), .lpm_halt(lpm_halt), .periph_clk_en(periph_clk_en), .irq(irq));
`default_nettype wire

// [pscs_top_test.sv]
// Self-checking bench for the PLL start-up supervisor
`timescale 1ns/100ps
`default_nettype none
module pscs_top_test;
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, osc, pll, lock, wake;
  logic        pll_run, pll_en, sel, tick, stall, idl, hlt, irq, ok;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pclk, d, p;
  logic [31:0] haddr, hwdata, hrdata, rd, st, r, m, v;
  int          fail_count = 0, cmp_count = 0, n = 0, k;
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h24, 8'h40};
  logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
  logic [1:0]  mm[4] = '{2'h1, 2'h3, 2'h2, 2'h3};
  logic [1:0]  me[4] = '{2'h2, 2'h2, 2'h1, 2'h1};
  assign hready = hreadyout;
  pscs_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .osc_clk_in(osc), .pll_clk_in(pll), .pll_lock_in(lock), .wake_req(wake), .pll_enable(pll_en),
    .system_clock_src_pll(sel), .system_clock_tick(tick), .cpu_stall(stall), .lpm_idle(idl), .lpm_halt(hlt),
    .periph_clk_en(pclk), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Oscillator period 8 cycles, PLL 6 cycles only while alive
  always @(posedge clk) begin
    n <= n + 1;
    if (n % 4 == 3) osc <= ~osc;
    if (n % 3 == 2) pll <= pll_run & pll_en & ~pll;
    lock <= pll_en;
  end
  function automatic logic early(input logic dn, er, input logic [31:0] rc, mc, vc);
    return (dn && (mc > 0 || rc > 0 || vc > 0)) || (er && mc > 0 && vc > 0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    {rst_n, hsel, hwrite, wake, osc, pll, lock, pll_run, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    void'($urandom(82311));
    wt(3);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    bus(1'b1, 8'h00, 32'h2);
    wt(3);
    chk({31'h0, stall}, 32'h1);
    bus(1'b1, 8'h00, 32'h3);
    wt(20);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'hF, 32'h9);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd & 32'hF, 32'hC);
    bus(1'b1, 8'h24, 32'h8);
    wt(3);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h24, 32'h0);
    wt(3);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h20, 32'hF);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd & 32'hF, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    wt(3);
    chk({30'h0, sel, stall}, 32'h0);
    bus(1'b1, 8'h14, 32'hA);
    bus(1'b1, 8'h18, 32'h10);
    bus(1'b1, 8'h1C, 32'h8);
    ok = 1'b0;
    for (int a = 0; a < 3 && !ok; a++) begin
      pll_run <= (a > 0);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, 32'h1);
      wt(12);
      k = 0;
      do begin
        bus(1'b0, 8'h0C, 32'h0);
        k++;
      end while (rd[0] !== 1'b1 && k < 50);
      bus(1'b1, 8'h10, 32'h1);
      wt(4);
      do bus(1'b0, 8'h10, 32'h0); while (rd[0] !== 1'b0);
      bus(1'b0, 8'h20, 32'h0);
      st = rd;
      bus(1'b0, 8'h14, 32'h0);
      r = rd;
      bus(1'b0, 8'h18, 32'h0);
      m = rd;
      bus(1'b0, 8'h1C, 32'h0);
      v = rd;
      chk(st & 32'h3, (a == 0) ? 32'h2 : 32'h1);
      chk({31'h0, early(st[0], st[1], r, m, v)}, 32'h0);
      ok = st[0] && !early(st[0], st[1], r, m, v);
      bus(1'b1, 8'h20, 32'hF);
    end
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h6, 32'h6);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    wt(20);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'h6, 32'h6);
    bus(1'b1, 8'h00, 32'h3);
    wt(5);
    chk({30'h0, sel, stall}, 32'h2);
    bus(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom % 8);
      bus(1'b1, 8'h04, {24'h0, d});
      repeat (2) do @(posedge clk); while (tick !== 1'b1);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (tick !== 1'b1 && k < 5000);
      chk(k, (d + 32'h1) * 32'h8);
    end
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 8'h00 : 8'($urandom);
      bus(1'b1, 8'h08, {24'h0, p});
      wt(3);
      chk({24'h0, pclk}, {24'h0, p});
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, {28'h0, mm[i], 2'b01});
      wt(3);
      chk({30'h0, idl, hlt}, {30'h0, me[i]});
    end
    chk({24'h0, pclk}, 32'h0);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wt(4);
    chk({22'h0, idl, hlt, pclk}, {24'h0, p});
    results();
  end
endmodule
`default_nettype wire
